// *** logic/ldr_consts.svh ***
// Purpose: Offsets, fields, reset values and timing for the link-detect,
//          scratch, interrupt-routing and split line-size register group
// Assumes: 100 MHz core clock, byte-wide host register port
// Notes:   Functional notes follow
//
// Functional notes
// R1: Link-detect drops when timeout passes with no valid reverse reception.
// R2: Three-bit timeout field at bits 2-0 picks eight periods; resets 000.
// R3: Two scratch bytes store writes, read back, reset A5h and 5Ah.
// R4: Routing field 0000 disables remote interrupt; 001x and 01xx reserved.
// R5: Code 0001: port 0 on remote pin, port 1 on local pin.
// R6: Independent links, other codes: remote interrupt combines both ports.
// R7: Codes 1000-1011 drive general pins 0-3; 1100-1111 secondary pins.
// R8: Thirteen-bit split line size: low byte, then bits 12:8.
// R9: Line size resets to 1280: low byte 0, upper bits 5.
// R10: Same line size serves as 2D line length in dual-input mode.
// R11: Software keeps line size at or below 4096 pixels.
// R12: Software selects the transmit port before port-specific accesses.
// R13: Timer restarts on each valid reception; reserved bits read zero.
`ifndef LDR_CONSTS_SVH
`define LDR_CONSTS_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define LDR_OFS_LINK_DET 8'h26
`define LDR_OFS_SCRATCH_A 8'h2e
`define LDR_OFS_SCRATCH_B 8'h2f
`define LDR_OFS_IRQ_ROUTE 8'h30
`define LDR_OFS_LINE_LOW 8'h32
`define LDR_OFS_LINE_HIGH 8'h33

// ------------------------------------------------------------
// Field masks and reset values
// ------------------------------------------------------------
`define LDR_MASK_LINK_DET 8'h07
`define LDR_MASK_IRQ_ROUTE 8'h0f
`define LDR_MASK_LINE_HIGH 8'h1f
`define LDR_RST_LINK_DET 3'h0
`define LDR_RST_SCRATCH_A 8'ha5
`define LDR_RST_SCRATCH_B 8'h5a
`define LDR_RST_IRQ_ROUTE 4'h0
`define LDR_RST_LINE_LOW 8'h00
`define LDR_RST_LINE_HIGH 5'h05

// ------------------------------------------------------------
// Timeout periods as printed, and the clock period
// ------------------------------------------------------------
`define LDR_CLK_PERIOD_NS 10.0
`define LDR_TMO0_MS 162.0
`define LDR_TMO1_MS 325.0
`define LDR_TMO2_MS 650.0
`define LDR_TMO3_MS 1.3
`define LDR_TMO4_US 10.25
`define LDR_TMO5_US 20.5
`define LDR_TMO6_US 41.0
`define LDR_TMO7_US 82.0
`define LDR_MS_CYC(t) int'((t) * 1.0e6 / `LDR_CLK_PERIOD_NS)
`define LDR_US_CYC(t) int'((t) * 1.0e3 / `LDR_CLK_PERIOD_NS)

`endif

// *** logic/ldr_pkg.sv ***
// Purpose: Types for the link-detect and interrupt-routing register group
// Assumes: Constants come from ldr_consts.svh
// Notes:   Route codes mirror the four-bit routing field
package ldr_pkg;
  typedef logic [7:0] ldr_byte_t;
  typedef logic [26:0] ldr_count_t;
  typedef enum logic [3:0] {
    LDR_ROUTE_OFF = 4'h0,
    LDR_ROUTE_SPLIT = 4'h1,
    LDR_ROUTE_GP0 = 4'h8,
    LDR_ROUTE_GP3 = 4'hb,
    LDR_ROUTE_SGP0 = 4'hc,
    LDR_ROUTE_SGP3 = 4'hf
  } ldr_route_e;
endpackage : ldr_pkg

// *** logic/ldr_regs.sv ***
// Purpose: Link-detect timer, scratch bytes, remote interrupt routing
//          and split line size, behind the host register port
// Assumes: All inputs come from logic on clk; no synchronisers needed
// Notes:   Read data appears one cycle after the read strobe
`include "ldr_consts.svh"

module ldr_regs #(
  parameter int unsigned TMO0_CYC = `LDR_MS_CYC(`LDR_TMO0_MS),
  parameter int unsigned TMO1_CYC = `LDR_MS_CYC(`LDR_TMO1_MS),
  parameter int unsigned TMO2_CYC = `LDR_MS_CYC(`LDR_TMO2_MS),
  parameter int unsigned TMO3_CYC = `LDR_MS_CYC(`LDR_TMO3_MS),
  parameter int unsigned TMO6_CYC = `LDR_US_CYC(`LDR_TMO6_US),
  parameter int unsigned TMO7_CYC = `LDR_US_CYC(`LDR_TMO7_US)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Host register port
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire ldr_pkg::ldr_byte_t regAddr,
  input wire ldr_pkg::ldr_byte_t regWrData,
  output ldr_pkg::ldr_byte_t regRdData,
  // Reverse control channel
  input wire logic rxValid,
  output logic linkDetect,
  // Interrupt sources
  input wire logic remIrqPort0,
  input wire logic remIrqPort1,
  input wire logic localIrqSrc,
  input wire logic dualLinkMode,
  // Interrupt pins
  output logic remoteIrqOutN,
  output logic localIrqOutN,
  output logic [3:0] gpIrqOut,
  output logic [3:0] secondaryGpIrqOut,
  // Splitter
  output logic [12:0] splitLineSize
);
  import ldr_pkg::*;

  // ------------------------------------------------------------
  // Timeout lengths
  // ------------------------------------------------------------
  localparam int unsigned TMO4_CYC = `LDR_US_CYC(`LDR_TMO4_US);
  localparam int unsigned TMO5_CYC = `LDR_US_CYC(`LDR_TMO5_US);

  function automatic ldr_count_t tmoCycles(input logic [2:0] sel);
    ldr_count_t c;
    c = ldr_count_t'(TMO0_CYC);
    case (sel)
      3'h0: c = ldr_count_t'(TMO0_CYC);
      3'h1: c = ldr_count_t'(TMO1_CYC);
      3'h2: c = ldr_count_t'(TMO2_CYC);
      3'h3: c = ldr_count_t'(TMO3_CYC);
      3'h4: c = ldr_count_t'(TMO4_CYC);
      3'h5: c = ldr_count_t'(TMO5_CYC);
      3'h6: c = ldr_count_t'(TMO6_CYC);
      default: c = ldr_count_t'(TMO7_CYC);
    endcase
    return c;
  endfunction : tmoCycles

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic [2:0] tmoSel_q;
  ldr_byte_t scratchA_q;
  ldr_byte_t scratchB_q;
  logic [3:0] routeSel_q;
  ldr_byte_t lineLow_q;
  logic [4:0] lineHigh_q;
  ldr_byte_t rdData_q;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  wire logic hitLinkDet = regAddr == `LDR_OFS_LINK_DET;
  wire logic hitScrA = regAddr == `LDR_OFS_SCRATCH_A;
  wire logic hitScrB = regAddr == `LDR_OFS_SCRATCH_B;
  wire logic hitRoute = regAddr == `LDR_OFS_IRQ_ROUTE;
  wire logic hitLineLow = regAddr == `LDR_OFS_LINE_LOW;
  wire logic hitLineHigh = regAddr == `LDR_OFS_LINE_HIGH;

  wire ldr_byte_t wrLinkDet = regWrData & `LDR_MASK_LINK_DET;
  wire ldr_byte_t wrRoute = regWrData & `LDR_MASK_IRQ_ROUTE;
  wire ldr_byte_t wrLineHigh = regWrData & `LDR_MASK_LINE_HIGH;

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  // Reserved bits are masked off before storing
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tmoSel_q <= `LDR_RST_LINK_DET; // [R2]
      scratchA_q <= `LDR_RST_SCRATCH_A; // [R3]
      scratchB_q <= `LDR_RST_SCRATCH_B; // [R3]
      routeSel_q <= `LDR_RST_IRQ_ROUTE; // [R4]
      lineLow_q <= `LDR_RST_LINE_LOW; // [R9]
      lineHigh_q <= `LDR_RST_LINE_HIGH; // [R9]
    end else if (regWrEn) begin
      if (hitLinkDet) begin
        tmoSel_q <= wrLinkDet[2:0]; // [R2] [R13]
      end
      if (hitScrA) begin
        scratchA_q <= regWrData; // [R3]
      end
      if (hitScrB) begin
        scratchB_q <= regWrData; // [R3]
      end
      if (hitRoute) begin
        routeSel_q <= wrRoute[3:0]; // [R13]
      end
      if (hitLineLow) begin
        lineLow_q <= regWrData; // [R8]
      end
      if (hitLineHigh) begin
        lineHigh_q <= wrLineHigh[4:0]; // [R8]
      end
    end
  end

  // ------------------------------------------------------------
  // Register reads
  // ------------------------------------------------------------
  // Unmapped offsets read zero
  wire ldr_byte_t rdMux =
    hitLinkDet ? {5'h00, tmoSel_q} : // [R13]
    hitScrA ? scratchA_q :
    hitScrB ? scratchB_q :
    hitRoute ? {4'h0, routeSel_q} : // [R13]
    hitLineLow ? lineLow_q :
    hitLineHigh ? {3'h0, lineHigh_q} : 8'h00;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdData_q <= 8'h00;
    end else if (regRdEn) begin
      rdData_q <= rdMux;
    end
  end

  assign regRdData = rdData_q;

  // ------------------------------------------------------------
  // Link-detect timer
  // ------------------------------------------------------------
  // Compare with >= so shortening the period mid-count cannot overrun
  ldr_count_t timerCnt_q;
  logic linked_q;
  wire ldr_count_t tmoLimit = tmoCycles(tmoSel_q); // [R2]
  wire logic timerExpire = linked_q && !rxValid &&
    (timerCnt_q >= tmoLimit - 27'h1);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timerCnt_q <= '0;
      linked_q <= 1'b0;
    end else if (rxValid) begin
      timerCnt_q <= '0; // [R13]
      linked_q <= 1'b1;
    end else if (timerExpire) begin
      timerCnt_q <= '0;
      linked_q <= 1'b0; // [R1]
    end else if (linked_q) begin
      timerCnt_q <= timerCnt_q + 27'h1;
    end
  end

  assign linkDetect = linked_q;

  // ------------------------------------------------------------
  // Remote interrupt routing
  // ------------------------------------------------------------
  // In dual-link operation only port 0 carries a link
  wire logic combinedIrq = dualLinkMode ? remIrqPort0 :
    (remIrqPort0 | remIrqPort1); // [R6]
  wire logic modeSplit = routeSel_q == LDR_ROUTE_SPLIT;
  wire logic modeGp = routeSel_q[3:2] == 2'b10;
  wire logic modeSgp = routeSel_q[3:2] == 2'b11;
  wire logic [3:0] pinOneHot = 4'h1 << routeSel_q[1:0];

  // Reserved codes behave as disabled
  wire logic remoteIrq = modeSplit & remIrqPort0; // [R5]
  wire logic localIrq = localIrqSrc | (modeSplit & remIrqPort1); // [R5]
  wire logic [3:0] gpIrq = (modeGp & combinedIrq) ? pinOneHot : 4'h0;
  wire logic [3:0] sgpIrq = (modeSgp & combinedIrq) ? pinOneHot : 4'h0;

  logic remoteIrqN_q;
  logic localIrqN_q;
  logic [3:0] gpIrq_q;
  logic [3:0] sgpIrq_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      remoteIrqN_q <= 1'b1;
      localIrqN_q <= 1'b1;
      gpIrq_q <= 4'h0;
      sgpIrq_q <= 4'h0;
    end else begin
      remoteIrqN_q <= !remoteIrq; // [R4] [R5]
      localIrqN_q <= !localIrq; // [R5]
      gpIrq_q <= gpIrq; // [R7]
      sgpIrq_q <= sgpIrq; // [R7]
    end
  end

  assign remoteIrqOutN = remoteIrqN_q;
  assign localIrqOutN = localIrqN_q;
  assign gpIrqOut = gpIrq_q;
  assign secondaryGpIrqOut = sgpIrq_q;

  // ------------------------------------------------------------
  // Split line size
  // ------------------------------------------------------------
  // Values above 4096 are not clamped; software must keep within it
  assign splitLineSize = {lineHigh_q, lineLow_q}; // [R8] [R10]

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_link_drop: assert property ( // [R1]
    @(posedge clk) disable iff (!reset_n)
    $fell(linkDetect) |-> $past(!rxValid) &&
      ($past(timerCnt_q) >= $past(tmoLimit) - 27'h1))
    else $error("link detect fell without timeout");

  chk_timer_restart: assert property ( // [R13]
    @(posedge clk) disable iff (!reset_n)
    rxValid |=> linkDetect && timerCnt_q == '0)
    else $error("timer not restarted on reception");

  chk_short_tmo: assert property ( // [R2]
    @(posedge clk) disable iff (!reset_n)
    (rxValid && tmoSel_q == 3'h4 && !regWrEn) ##1
      (!rxValid && !regWrEn) [*8] |-> linkDetect)
    else $error("short timeout expired too early");

  chk_scratch_store: assert property ( // [R3]
    @(posedge clk) disable iff (!reset_n)
    (regWrEn && hitScrB) |=> scratchB_q == $past(regWrData))
    else $error("scratch byte not stored");

  chk_route_off: assert property ( // [R4]
    @(posedge clk) disable iff (!reset_n)
    routeSel_q == LDR_ROUTE_OFF |=>
      remoteIrqOutN && gpIrqOut == 4'h0 && secondaryGpIrqOut == 4'h0)
    else $error("interrupt routed while disabled");

  chk_split_ports: assert property ( // [R5]
    @(posedge clk) disable iff (!reset_n)
    modeSplit |=> remoteIrqOutN == !$past(remIrqPort0) &&
      localIrqOutN == !($past(remIrqPort1) || $past(localIrqSrc)))
    else $error("split interrupt pins wrong");

  chk_combined_gp: assert property ( // [R6]
    @(posedge clk) disable iff (!reset_n)
    (routeSel_q == LDR_ROUTE_GP0 && !dualLinkMode && remIrqPort1) |=>
      gpIrqOut == 4'h1)
    else $error("port 1 missing from combined interrupt");

  chk_sgp_route: assert property ( // [R7]
    @(posedge clk) disable iff (!reset_n)
    (routeSel_q == LDR_ROUTE_SGP3 && remIrqPort0) |=>
      secondaryGpIrqOut == 4'h8 && gpIrqOut == 4'h0)
    else $error("secondary pin routing wrong");

  chk_line_write: assert property ( // [R8]
    @(posedge clk) disable iff (!reset_n)
    (regWrEn && hitLineHigh) |=>
      splitLineSize[12:8] == $past(regWrData[4:0]))
    else $error("line size upper bits not stored");

  chk_line_reset: assert property ( // [R9]
    @(posedge clk)
    $rose(reset_n) |-> splitLineSize == 13'h0500)
    else $error("line size reset value wrong");

  chk_reserved_zero: assert property ( // [R13]
    @(posedge clk) disable iff (!reset_n)
    (regRdEn && (hitLinkDet || hitRoute)) |=> regRdData[7:4] == 4'h0)
    else $error("reserved bits read nonzero");

  chk_scratch_a_store: assert property ( // [R3]
    @(posedge clk) disable iff (!reset_n)
    (regWrEn && hitScrA) |=> scratchA_q == $past(regWrData))
    else $error("scratch byte a not stored");

  chk_route_reserved: assert property ( // [R4]
    @(posedge clk) disable iff (!reset_n)
    (routeSel_q[3:2] == 2'b01 || routeSel_q[3:1] == 3'b001) |=>
      remoteIrqOutN && gpIrqOut == 4'h0 && secondaryGpIrqOut == 4'h0)
    else $error("reserved route code drove a pin");

  chk_line_low: assert property ( // [R8]
    @(posedge clk) disable iff (!reset_n)
    (regWrEn && hitLineLow) |=>
      splitLineSize[7:0] == $past(regWrData))
    else $error("line size low byte not stored");

  chk_link_rise: assert property ( // [R13]
    @(posedge clk) disable iff (!reset_n)
    $rose(linkDetect) |-> $past(rxValid))
    else $error("link detect rose without reception");

endmodule : ldr_regs

// *** sim/ldr_regs_tb.sv ***
// Purpose: Self-checking bench for the ldr_regs register group
// Assumes: Inputs change at the falling edge; shortened timer counts
// Notes:   Codes 0 to 3 are shortened, codes 4 to 7 keep full counts
`define CHK(nm, e, g) check_val(nm, 32'(e), 32'(g))

module ldr_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ldr_pkg::*;

  // ----------------------------------------------------------
  // Signals and tables
  // ----------------------------------------------------------
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic regWrEn = 1'b0, regRdEn = 1'b0, rxValid = 1'b0;
  ldr_byte_t regAddr = 8'h00, regWrData = 8'h00, regRdData, rdVal;
  logic remIrqPort0 = 1'b0, remIrqPort1 = 1'b0;
  logic localIrqSrc = 1'b0, dualLinkMode = 1'b0;
  logic remoteIrqOutN, localIrqOutN, linkDetect;
  logic [3:0] gpIrqOut, secondaryGpIrqOut;
  logic [12:0] splitLineSize;
  int mismatches = 0;
  int tests_run = 0;
  int tmoCyc [8] = '{200, 300, 400, 500, 1025, 2050, 4100, 8200};
  ldr_byte_t ofs [6] = '{8'h26, 8'h2e, 8'h2f, 8'h30, 8'h32, 8'h33};
  ldr_byte_t rstv [6] = '{8'h00, 8'ha5, 8'h5a, 8'h00, 8'h00, 8'h05};
  ldr_byte_t msk [6] = '{8'h07, 8'hff, 8'hff, 8'h0f, 8'hff, 8'h1f};
  // Upper line-size byte keeps the total within 4096 pixels
  ldr_byte_t ones [6] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hf0};

  always #5 clk = ~clk;

  ldr_regs #(.TMO0_CYC(200), .TMO1_CYC(300), .TMO2_CYC(400),
    .TMO3_CYC(500)) i_dut (
    .clk(clk), .reset_n(reset_n), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .rxValid(rxValid), .linkDetect(linkDetect),
    .remIrqPort0(remIrqPort0), .remIrqPort1(remIrqPort1),
    .localIrqSrc(localIrqSrc), .dualLinkMode(dualLinkMode),
    .remoteIrqOutN(remoteIrqOutN), .localIrqOutN(localIrqOutN),
    .gpIrqOut(gpIrqOut), .secondaryGpIrqOut(secondaryGpIrqOut),
    .splitLineSize(splitLineSize));

  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task check_val(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : check_val

  task results;
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  task wr(input ldr_byte_t a, input ldr_byte_t d);
    @(negedge clk);
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    @(negedge clk);
    regWrEn = 1'b0;
  endtask : wr

  task rd(input ldr_byte_t a);
    @(negedge clk);
    regRdEn = 1'b1;
    regAddr = a;
    @(negedge clk);
    regRdEn = 1'b0;
    rdVal = regRdData;
  endtask : rd

  task pulse;
    @(negedge clk);
    rxValid = 1'b1;
    @(negedge clk);
    rxValid = 1'b0;
  endtask : pulse

  // Late second reception must restart the full count
  task tmo(input int code);
    int k;
    wr(8'h26, 8'(code));
    pulse();
    `CHK("linkDetect up", 1'b1, linkDetect);
    repeat (tmoCyc[code] - 2) @(negedge clk);
    `CHK("linkDetect held", 1'b1, linkDetect);
    pulse();
    k = 0;
    while (linkDetect === 1'b1 && k < 20000) begin
      @(negedge clk);
      k++;
    end
    `CHK("timeout cycles", tmoCyc[code], k);
  endtask : tmo

  task route_check(input logic [3:0] c);
    logic [3:0] iv, eg, es;
    logic comb, er, el;
    wr(8'h30, {4'h0, c});
    for (int i = 0; i < 16; i++) begin
      iv = 4'(i);
      {remIrqPort0, remIrqPort1, localIrqSrc, dualLinkMode} = iv;
      comb = iv[0] ? iv[3] : (iv[3] | iv[2]);
      er = !(c == 4'h1 && iv[3]);
      el = !(iv[1] | (c == 4'h1 && iv[2]));
      eg = (c[3:2] == 2'b10 && comb) ? 4'h1 << c[1:0] : 4'h0;
      es = (c[3:2] == 2'b11 && comb) ? 4'h1 << c[1:0] : 4'h0;
      repeat (2) @(negedge clk);
      `CHK("remoteIrqOutN", er, remoteIrqOutN);
      `CHK("localIrqOutN", el, localIrqOutN);
      `CHK("gpIrqOut", eg, gpIrqOut);
      `CHK("secondaryGpIrqOut", es, secondaryGpIrqOut);
    end
  endtask : route_check

  // ----------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------
  initial begin
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    `CHK("splitLineSize", 13'h500, splitLineSize);
    wr(8'h1e, 8'h01);
    for (int i = 0; i < 6; i++) begin
      rd(ofs[i]);
      `CHK("reset value", rstv[i], rdVal);
    end
    for (int i = 0; i < 6; i++) begin
      wr(ofs[i], ones[i]);
      rd(ofs[i]);
      `CHK("ones readback", ones[i] & msk[i], rdVal);
      wr(ofs[i], 8'h00);
      rd(ofs[i]);
      `CHK("zero readback", 8'h00, rdVal);
    end
    wr(8'h27, 8'hff);
    rd(8'h27);
    `CHK("unmapped read", 8'h00, rdVal);
    // Read and write in one cycle: old value comes back
    @(negedge clk);
    {regWrEn, regRdEn, regAddr, regWrData} = {2'b11, 8'h2e, 8'h3c};
    @(negedge clk);
    {regWrEn, regRdEn} = 2'b00;
    `CHK("read old", 8'h00, regRdData);
    rd(8'h2e);
    `CHK("scratch a", 8'h3c, rdVal);
    wr(8'h32, 8'hff);
    wr(8'h33, 8'h0f);
    `CHK("splitLineSize", 13'h0fff, splitLineSize);
    for (int c = 0; c < 16; c++) route_check(4'(c));
    for (int c = 0; c < 8; c++) tmo(c);
    wr(8'h2f, 8'h77);
    // Bring the link up so the reset has something to clear
    pulse();
    @(negedge clk);
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    `CHK("linkDetect reset", 1'b0, linkDetect);
    `CHK("splitLineSize", 13'h500, splitLineSize);
    rd(8'h2f);
    `CHK("scratch b reset", 8'h5a, rdVal);
    results();
  end

  // Expected run is about 34200 cycles
  initial begin
    #600000;
    mismatches++;
    results();
  end
endmodule : ldr_regs_tb
